// file: core/iopm_pkg.sv
package iopm_pkg;
    localparam int PIN_COUNT = 8;
    localparam int FUNC_COUNT = 32;
    localparam int BUS_WIDTH = 10;
    localparam int ROUTE_WIDTH = 6;
    localparam int DIR_BIT = 5;
    localparam int SEL_MSB = 4;

    localparam logic [9:0] ADDR_TEST0 = 10'h00D;
    localparam logic [9:0] ADDR_PIN_FIRST = 10'h00F;
    localparam logic [9:0] ADDR_PIN_LAST = 10'h016;
    localparam logic [9:0] ADDR_TEST_ENABLES = 10'h055;
    localparam logic [9:0] ADDR_STATUS_LO = 10'h060;
    localparam logic [9:0] ADDR_STATUS_HI = 10'h061;

    // test 0 layout: pattern select word in [5:0], generator enable in [6]
    localparam int TEST0_GEN_BIT = 6;
    localparam logic [6:0] TEST0_RESET = 7'h00;

    // test enables layout
    localparam int TE_SCRAMBLE = 0;
    localparam int TE_NRZI = 1;
    localparam int TE_CLIP = 2;
    localparam int TE_SYNC = 3;
    localparam logic [3:0] TEST_ENABLES_RESET = 4'hF;

    // input function carrying the pattern generator enable
    localparam logic [4:0] FUNC_GEN_ENABLE = 5'h01;

    // per-pin power-on routes, pin 7 first
    localparam logic [47:0] ROUTE_RESET = {
        6'h21, 6'h1D, 6'h04, 6'h1C, 6'h19, 6'h14, 6'h11, 6'h12
    };

    typedef enum logic [0:0] {
        PH_ADDR = 1'b0,
        PH_DATA = 1'b1
    } iopm_phase_type;

    typedef enum logic [1:0] {
        PAT_BLACK = 2'b00,
        PAT_PLL_PATH = 2'b01,
        PAT_EQ_PATH = 2'b10,
        PAT_COLOR_BARS = 2'b11
    } iopm_pattern_type;
endpackage

// file: core/iopm_route_if.sv
`timescale 1ns/1ps
interface iopm_route_if;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [5:0] wr_data;
    logic [2:0] rd_idx;
    logic [5:0] rd_data;
    logic [47:0] routes;

    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx,
                  input rd_data, input routes);
    modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx,
                  output rd_data, output routes);
endinterface

// file: core/iopm_route_bank.sv
`timescale 1ns/1ps
module iopm_route_bank (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    iopm_route_if.bank bus
);
    logic [5:0] entry [8];
    logic [5:0] rd_data;

    genvar g;
    generate
        for (g = 0; g < iopm_pkg::PIN_COUNT; g++) begin : g_entry
            always_ff @(posedge sys_clk_i) begin
                if (!nrst_i) begin
                    entry[g] <= iopm_pkg::ROUTE_RESET[g*6 +: 6];
                end else if (bus.wr_en && bus.wr_idx == 3'(g)) begin
                    entry[g] <= bus.wr_data;
                end
            end
            assign bus.routes[g*6 +: 6] = entry[g];
        end
    endgenerate

    // read data from a register, one cycle behind rd_idx
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rd_data <= 6'h00;
        end else begin
            rd_data <= entry[bus.rd_idx];
        end
    end
    assign bus.rd_data = rd_data;
endmodule // iopm_route_bank

// file: core/iopm_ctrl.sv
`timescale 1ns/1ps
module iopm_ctrl (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ctrl_space_select_i,
    input wire logic rd_wr_i,
    input wire logic port_clk_i,
    input wire logic [9:0] ad_i,
    output logic [9:0] ad_o,
    output logic ad_oe_n_o,
    input wire logic [7:0] io_i,
    output logic [7:0] io_o,
    output logic [7:0] io_oe_n_o,
    input wire logic [31:0] func_status_i,
    output logic [31:0] func_drive_o,
    output logic [31:0] func_from_pin_o,
    output logic scrambler_on_o,
    output logic nrzi_on_o,
    output logic lsb_clip_on_o,
    output logic sync_detect_on_o,
    output logic pattern_generator_on_o,
    output logic [5:0] pattern_select_o,
    output logic pattern_hd_o,
    output logic pattern_progressive_o,
    output logic [1:0] pattern_sub_format_o,
    output logic [1:0] pattern_kind_o
);
    ////////////////////////////////////////////////////////////////////////////
    iopm_route_if route ();

    iopm_route_bank u_bank (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .bus(route.bank)
    );

    ////////////////////////////////////////////////////////////////////////////
    iopm_pkg::iopm_phase_type phase;
    iopm_pkg::iopm_phase_type next_phase;
    logic port_clk_q;
    logic [9:0] addr_q;
    logic rd_q;
    logic [6:0] test0;
    logic [3:0] test_en;
    logic [9:0] rd_word;
    logic [9:0] ad_q;
    logic drive_q;
    logic [7:0] io_q;
    logic [7:0] io_oe_n_q;
    logic [31:0] from_pin;
    logic [31:0] pin_value;
    logic [31:0] from_pin_q;
    logic [31:0] pin_value_q;
    logic gen_on_q;

    // port clock is taken as a synchronous level; only its rise counts
    wire port_edge = port_clk_i & ~port_clk_q;
    wire ctrl_edge = port_edge & ~ctrl_space_select_i;
    wire addr_edge = ctrl_edge && phase == iopm_pkg::PH_ADDR;
    wire data_edge = ctrl_edge && phase == iopm_pkg::PH_DATA;
    // select low and read/write low mark a write
    wire wr_strobe = data_edge & ~rd_q;
    wire rd_done = data_edge & rd_q;

    wire hit_pin = addr_q >= iopm_pkg::ADDR_PIN_FIRST && addr_q <= iopm_pkg::ADDR_PIN_LAST;
    wire [9:0] pin_off = addr_q - iopm_pkg::ADDR_PIN_FIRST;
    wire hit_test0 = addr_q == iopm_pkg::ADDR_TEST0;
    wire hit_ten = addr_q == iopm_pkg::ADDR_TEST_ENABLES;

    // address on the first port clock, data on the second
    always_comb begin
        next_phase = phase;
        if (ctrl_space_select_i) begin
            next_phase = iopm_pkg::PH_ADDR;
        end else if (ctrl_edge) begin
            next_phase = (phase == iopm_pkg::PH_ADDR) ? iopm_pkg::PH_DATA : iopm_pkg::PH_ADDR;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            phase <= iopm_pkg::PH_ADDR;
            port_clk_q <= 1'b0;
            addr_q <= 10'h000;
            rd_q <= 1'b0;
        end else begin
            phase <= next_phase;
            port_clk_q <= port_clk_i;
            if (addr_edge) begin
                addr_q <= ad_i;
                rd_q <= rd_wr_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // route registers live in the bank, indexed from 0Fh
    assign route.wr_en = wr_strobe & hit_pin;
    assign route.wr_idx = pin_off[2:0];
    // data 30Dh keeps 0Dh: output, video start status
    assign route.wr_data = ad_i[5:0];
    assign route.rd_idx = pin_off[2:0];

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            test0 <= iopm_pkg::TEST0_RESET;
        end else if (wr_strobe && hit_test0) begin
            test0 <= ad_i[6:0];
        end
    end

    // a completed read of 55h sets all four again
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            test_en <= iopm_pkg::TEST_ENABLES_RESET;
        end else if (rd_done && hit_ten) begin
            test_en <= iopm_pkg::TEST_ENABLES_RESET;
        end else if (wr_strobe && hit_ten) begin
            test_en <= ad_i[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; route data lags the address by one cycle, so sampled later
    always_comb begin
        rd_word = 10'h000;
        if (hit_pin) begin
            rd_word = {4'h0, route.rd_data};
        end else if (hit_test0) begin
            rd_word = {3'h0, test0};
        end else if (hit_ten) begin
            rd_word = {6'h00, test_en};
        end else if (addr_q == iopm_pkg::ADDR_STATUS_LO) begin
            rd_word = func_status_i[9:0];
        end else if (addr_q == iopm_pkg::ADDR_STATUS_HI) begin
            rd_word = func_status_i[19:10];
        end
    end

    // bus driven through the data phase of a read only
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ad_q <= 10'h000;
            drive_q <= 1'b0;
        end else begin
            ad_q <= rd_word;
            drive_q <= rd_q && phase == iopm_pkg::PH_DATA && !ctrl_space_select_i && !rd_done;
        end
    end
    assign ad_o = ad_q;
    assign ad_oe_n_o = ~drive_q;

    ////////////////////////////////////////////////////////////////////////////
    // input functions: a pin in input mode takes over the register bit
    genvar f;
    generate
        for (f = 0; f < iopm_pkg::FUNC_COUNT; f++) begin : g_func
            logic [7:0] hit;
            for (genvar p = 0; p < iopm_pkg::PIN_COUNT; p++) begin : g_pin
                // low five bits name the function
                assign hit[p] = route.routes[p*6 + iopm_pkg::DIR_BIT]
                    && route.routes[p*6 +: 5] == 5'(f);
            end
            assign from_pin[f] = |hit;
            assign pin_value[f] = |(hit & io_i);
        end
    endgenerate

    // registered so no pin-to-output comb path leaves the block
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            from_pin_q <= 32'h00000000;
            pin_value_q <= 32'h00000000;
        end else begin
            from_pin_q <= from_pin;
            pin_value_q <= pin_value;
        end
    end
    assign func_from_pin_o = from_pin_q;
    assign func_drive_o = pin_value_q;

    // pins in output mode show the chosen status bit, registered
    generate
        for (genvar p = 0; p < iopm_pkg::PIN_COUNT; p++) begin : g_out
            always_ff @(posedge sys_clk_i) begin
                if (!nrst_i) begin
                    io_q[p] <= 1'b0;
                    io_oe_n_q[p] <= 1'b1;
                end else begin
                    // output pins carry status only; host keeps codes sane
                    io_q[p] <= func_status_i[route.routes[p*6 +: 5]];
                    io_oe_n_q[p] <= route.routes[p*6 + iopm_pkg::DIR_BIT];
                end
            end
        end
    endgenerate
    assign io_o = io_q;
    assign io_oe_n_o = io_oe_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // scrambler, NRZI, LSB clip and sync detect enables
    assign scrambler_on_o = test_en[iopm_pkg::TE_SCRAMBLE];
    assign nrzi_on_o = test_en[iopm_pkg::TE_NRZI];
    assign lsb_clip_on_o = test_en[iopm_pkg::TE_CLIP];
    assign sync_detect_on_o = test_en[iopm_pkg::TE_SYNC];

    // any pin routed as input to function 01h overrides the register bit
    wire gen_from_pin = from_pin[iopm_pkg::FUNC_GEN_ENABLE];
    wire next_gen_on = gen_from_pin ? pin_value[iopm_pkg::FUNC_GEN_ENABLE]
        : test0[iopm_pkg::TEST0_GEN_BIT];

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            gen_on_q <= 1'b0;
        end else begin
            gen_on_q <= next_gen_on;
        end
    end
    assign pattern_generator_on_o = gen_on_q;

    assign pattern_select_o = test0[5:0];
    assign pattern_hd_o = test0[5];
    assign pattern_progressive_o = test0[4];
    assign pattern_sub_format_o = test0[3:2];
    assign pattern_kind_o = test0[1:0];
endmodule // iopm_ctrl

// file: verif/iopm_host.sv
`timescale 1ns/1ps
module iopm_host (
    input wire logic sys_clk_i,
    input wire logic [9:0] ad_o_i,
    output logic sel_o,
    output logic rd_wr_o,
    output logic pclk_o,
    output logic [9:0] ad_out_o
);
    initial begin
        sel_o = 1'b1;
        rd_wr_o = 1'b1;
        pclk_o = 1'b0;
        ad_out_o = 10'h000;
    end
    ////////////////////////////////////////
    // address then data
    task automatic xfer(input logic rw, input logic [9:0] a, input logic [9:0] d,
                        output logic [9:0] rdata);
        @(posedge sys_clk_i) #1;
        sel_o = 1'b0;
        rd_wr_o = rw;
        ad_out_o = a;
        pclk_o = 1'b1;
        repeat (2) @(posedge sys_clk_i) #1;
        pclk_o = 1'b0;
        @(posedge sys_clk_i) #1;
        rdata = ad_o_i;
        ad_out_o = d;
        @(posedge sys_clk_i) #1;
        pclk_o = 1'b1;
        repeat (2) @(posedge sys_clk_i) #1;
        pclk_o = 1'b0;
        sel_o = 1'b1;
        // released bus: inverse, so no stale word is mistaken for data
        ad_out_o = ~d;
    endtask
endmodule // iopm_host

// file: verif/iopm_ctrl_asserts.sv
`timescale 1ns/1ps
module iopm_ctrl_asserts (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic ctrl_space_select_i,
    input wire logic rd_wr_i,
    input wire logic port_clk_i,
    input wire logic [9:0] ad_i,
    input wire logic ad_oe_n_o,
    input wire logic [7:0] io_oe_n_o,
    input wire logic scrambler_on_o,
    input wire logic nrzi_on_o,
    input wire logic lsb_clip_on_o,
    input wire logic sync_detect_on_o,
    input wire logic pattern_hd_o,
    input wire logic [1:0] pattern_kind_o,
    input wire logic [5:0] pattern_select_o
);
    logic pclk_q, ph_q, rw_q;
    logic [9:0] addr_q;
    wire rise = port_clk_i & ~pclk_q & ~ctrl_space_select_i;
    wire dat = rise & ph_q;
    wire dat55 = dat & (addr_q == 10'h055);
    wire [3:0] en = {sync_detect_on_o, lsb_clip_on_o, nrzi_on_o, scrambler_on_o};
    // phase tracker mirrors the port, select high restarts it
    always_ff @(posedge sys_clk_i) begin
        pclk_q <= port_clk_i & nrst_i;
        if (!nrst_i || ctrl_space_select_i) begin
            ph_q <= 1'b0;
        end else if (rise) begin
            ph_q <= ~ph_q;
        end
        if (rise && !ph_q) begin
            addr_q <= ad_i;
            rw_q <= rd_wr_i;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    pattern_split_a:
        assert property (pattern_hd_o == pattern_select_o[5] && pattern_kind_o ==
            pattern_select_o[1:0]) else $error("pattern fields off");
    enables_reset_a:
        assert property ($rose(nrst_i) |-> en == 4'hF) else $error("enables not on");
    enables_write_a:
        assert property (dat55 && !rw_q |=> en == $past(ad_i[3:0])) else $error("enables write");
    read_restore_a:
        assert property (dat55 && rw_q |=> en == 4'hF) else $error("enables not restored");
    enables_hold_a:
        assert property (!dat55 |=> $stable(en)) else $error("enables moved");
    read_drive_a:
        assert property (rise && !ph_q && rd_wr_i |-> ##2 !ad_oe_n_o) else $error("no read drive");
    bus_release_a:
        assert property (ctrl_space_select_i [*3] |-> ad_oe_n_o) else $error("bus held");
    pin0_output_a:
        assert property (dat && !rw_q && addr_q == 10'h00F && !ad_i[5] |-> ##[1:3]
            !io_oe_n_o[0]) else $error("pin 0 not output");
    cover property (dat55 && rw_q);
    cover property (dat && addr_q == 10'h00F);
    cover property (pattern_hd_o && pattern_kind_o == 2'b11);
endmodule // iopm_ctrl_asserts

bind iopm_ctrl iopm_ctrl_asserts iopm_ctrl_asserts_inst (
    .sys_clk_i, .nrst_i, .ctrl_space_select_i, .rd_wr_i, .port_clk_i, .ad_i, .ad_oe_n_o,
    .io_oe_n_o, .scrambler_on_o, .nrzi_on_o, .lsb_clip_on_o, .sync_detect_on_o,
    .pattern_hd_o, .pattern_kind_o, .pattern_select_o
);

// file: verif/iopm_ctrl_tb_top.sv
`timescale 1ns/1ps
module iopm_ctrl_tb_top;
    logic sys_clk_i, nrst_i, ctrl_space_select_i, rd_wr_i, port_clk_i;
    logic [9:0] ad_i, ad_o, rd_q;
    logic [7:0] io_i, io_o, io_oe_n_o;
    logic [31:0] func_status_i, func_from_pin_o, func_drive_o;
    logic ad_oe_n_o;
    logic scrambler_on_o, nrzi_on_o, lsb_clip_on_o, sync_detect_on_o, pattern_generator_on_o;
    logic pattern_hd_o, pattern_progressive_o;
    logic [1:0] pattern_sub_format_o, pattern_kind_o;
    logic [5:0] pattern_select_o;
    int fails = 0;
    int n_compared = 0;
    wire [3:0] en = {sync_detect_on_o, lsb_clip_on_o, nrzi_on_o, scrambler_on_o};
    wire [6:0] pat = {pattern_generator_on_o, pattern_hd_o, pattern_progressive_o,
        pattern_sub_format_o, pattern_kind_o};
    iopm_ctrl iopm_ctrl_inst (.sys_clk_i, .nrst_i, .ctrl_space_select_i, .rd_wr_i,
        .port_clk_i, .ad_i, .ad_o, .ad_oe_n_o, .io_i, .io_o, .io_oe_n_o, .func_status_i,
        .func_drive_o, .func_from_pin_o, .scrambler_on_o, .nrzi_on_o, .lsb_clip_on_o,
        .sync_detect_on_o, .pattern_generator_on_o, .pattern_select_o, .pattern_hd_o,
        .pattern_progressive_o, .pattern_sub_format_o, .pattern_kind_o);
    iopm_host iopm_host_inst (.sys_clk_i(sys_clk_i), .ad_o_i(ad_o),
        .sel_o(ctrl_space_select_i), .rd_wr_o(rd_wr_i), .pclk_o(port_clk_i), .ad_out_o(ad_i));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i) #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [9:0] d);
        iopm_host_inst.xfer(1'b0, a, d, rd_q);
    endtask
    task automatic rd(input logic [9:0] a);
        iopm_host_inst.xfer(1'b1, a, 10'h000, rd_q);
    endtask
    task automatic t_defaults();
        check(32'(en), 32'hF);
        check(32'(io_oe_n_o), 32'h80);
        check(32'(pattern_select_o), 32'h0);
        io_i = 8'h80;
        tick(2);
        check(32'(pattern_generator_on_o), 32'h1);
        check(func_from_pin_o, 32'(1) << iopm_pkg::FUNC_GEN_ENABLE);
        check(func_drive_o, 32'(1) << iopm_pkg::FUNC_GEN_ENABLE);
        io_i = 8'h00;
        tick(2);
        check(32'(pattern_generator_on_o), 32'h0);
        check(func_drive_o, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rd(iopm_pkg::ADDR_PIN_FIRST + 10'(i));
            check(32'(rd_q), 32'(iopm_pkg::ROUTE_RESET[6*i +: 6]));
        end
    endtask
    task automatic t_routes();
        // input-only code kept on input pins
        for (int i = 0; i < 8; i++) wr(iopm_pkg::ADDR_PIN_FIRST + 10'(i), 10'h020);
        check(32'(io_oe_n_o), 32'hFF);
        check(32'(func_from_pin_o[0]), 32'h1);
        for (int i = 0; i < 8; i++) wr(iopm_pkg::ADDR_PIN_FIRST + 10'(i), 10'h30D);
        func_status_i = 32'h00002000;
        tick(2);
        check(32'(io_oe_n_o), 32'h0);
        check(32'(io_o), 32'hFF);
        func_status_i = 32'hFFFFDFFF;
        tick(2);
        check(32'(io_o), 32'h0);
        rd(iopm_pkg::ADDR_PIN_FIRST);
        check(32'(rd_q), 32'h00D);
    endtask
    task automatic t_pattern();
        logic [6:0] w [5] = '{7'h64, 7'h65, 7'h66, 7'h67, 7'h1A};
        for (int k = 0; k < 5; k++) begin
            wr(iopm_pkg::ADDR_TEST0, {3'h0, w[k]});
            check(32'(pat), 32'(w[k]));
        end
    endtask
    task automatic t_enables();
        logic [3:0] v [3] = '{4'h5, 4'hA, 4'h0};
        for (int k = 0; k < 3; k++) begin
            wr(iopm_pkg::ADDR_TEST_ENABLES, {6'h0, v[k]});
            check(32'(en), 32'(v[k]));
            rd(iopm_pkg::ADDR_TEST_ENABLES);
            check(32'(rd_q), 32'(v[k]));
            check(32'(en), 32'hF);
            check(32'(ad_oe_n_o), 32'h1);
        end
    endtask
    task automatic t_unmapped();
        wr(10'h3FF, 10'h3FF);
        rd(10'h3FF);
        check(32'(rd_q), 32'h0);
        rd(10'h007);
        check(32'(rd_q), 32'h0);
        func_status_i = 32'h00055AA5;
        rd(iopm_pkg::ADDR_STATUS_LO);
        check(32'(rd_q), 32'h2A5);
        rd(iopm_pkg::ADDR_STATUS_HI);
        check(32'(rd_q), 32'h156);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        nrst_i = 1'b0;
        io_i = 8'h00;
        func_status_i = 32'h0;
        tick(10);
        nrst_i = 1'b1;
        tick(2);
        t_defaults();
        t_routes();
        t_pattern();
        t_enables();
        t_unmapped();
        end_of_test();
    end
    // about 307 cycles expected, so 4000 is ample
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
endmodule // iopm_ctrl_tb_top
